// File: rtl/global_interrupt_aggregator.sv
// Top-level interrupt aggregation with byte-wide big-endian register access.
`timescale 1ns/1ps
`include "irq_agg_defines.svh"

module global_interrupt_aggregator
    import irq_agg_pkg::*;
#(
    parameter int NUM_LOOKUP_SRC = 8,
    parameter int NUM_GPIO_SRC   = 4
)(
    input  wire logic                      i_core_clk,
    input  wire logic                      i_srst,
    input  wire logic                      i_wr_en,
    input  wire logic                      i_rd_en,
    input  wire logic [15:0]               i_addr,
    input  wire logic [7:0]                i_wdata,
    input  wire logic [NUM_LOOKUP_SRC-1:0] i_lookup_engine_src,
    input  wire logic [NUM_GPIO_SRC-1:0]   i_gpio_ts_src,
    input  wire logic [4:0]                i_port_pending,
    output logic [7:0]                     o_rdata,
    output logic                           o_rvalid,
    output logic                           o_irq
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (NUM_LOOKUP_SRC < 1 || NUM_GPIO_SRC < 1)
    begin : g_bad_param
        $error("Source counts must be at least one.");
    end

    // ------------------------------------------------------------------
    // Status words
    // ------------------------------------------------------------------
    byte_req_s   req;
    agg_state_s  st_r;
    agg_state_s  st_nxt;
    logic [31:0] gstat;
    logic [31:0] pstat;

    assign req = '{wr_en: i_wr_en, rd_en: i_rd_en,
                   addr: i_addr, wdata: i_wdata};

    // Flags are live ORs so they drop as soon as software clears the
    // detailed sources; per-port timestamp events are carried only by
    // i_port_pending, never by the GPIO input.
    always_comb
    begin
        gstat = 32'h00000000;
        gstat[`GIRQ_LOOKUP_BIT] = |i_lookup_engine_src;
        gstat[`GIRQ_GPIO_BIT]   = |i_gpio_ts_src;
        pstat = 32'h00000000;
        pstat[3:0] = i_port_pending[3:0];
        pstat[`PIRQ_PORT5_BIT] = i_port_pending[4];
    end

    // ------------------------------------------------------------------
    // Byte access helpers
    // ------------------------------------------------------------------
    // Byte 0 of a word is its most significant byte.
    function automatic logic [7:0] pick_byte(input logic [31:0] w,
                                             input logic [1:0]  b);
        pick_byte = w[8*(3-b) +: 8];
    endfunction : pick_byte

    function automatic logic [31:0] put_byte(input logic [31:0] w,
                                             input logic [1:0]  b,
                                             input logic [7:0]  d,
                                             input logic [31:0] used);
        logic [31:0] t;
        t = w;
        t[8*(3-b) +: 8] = d;
        put_byte = t & used;
    endfunction : put_byte

    // A flag only requests service while its mask bit is clear.
    function automatic logic any_unmasked(input logic [31:0] flags,
                                          input logic [31:0] mask);
        any_unmasked = |(flags & ~mask);
    endfunction : any_unmasked

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    // Four 32-bit words are decoded, each reached as four byte lanes.
    // The host interface is byte wide, so a word is never written as a
    // whole; a mask update spread over several bytes is applied one lane
    // at a time, and software must expect the combined request to follow
    // each lane as it lands.
    //
    // Status words are rebuilt every cycle from the source levels and so
    // need no storage of their own. This keeps them from going stale
    // when a source is cleared, at the cost of a read showing whatever
    // the sources hold in the cycle of the read.
    //
    // Mask words are the only writable state. Bits outside the defined
    // mask positions are forced to zero on every write so that they
    // always read back as zero.
    //
    // Addresses that fall outside the four words still answer a read,
    // with a zero byte, so a host polling a wrong address is not left
    // waiting for a response that never comes.
    //
    // A read and a write in the same cycle are both served; the read
    // returns the value held before the write lands.

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    logic [15:0] word_addr;
    logic [1:0]  byte_sel;

    always_comb
    begin
        word_addr = {req.addr[15:2], 2'b00};
        byte_sel  = req.addr[1:0];
        st_nxt    = st_r;
        st_nxt.rvalid_r = req.rd_en;
        if (req.rd_en)
        begin
            case (word_addr)
                `GIRQ_STATUS_OFS: st_nxt.rdata_r = pick_byte(gstat, byte_sel);
                `GIRQ_MASK_OFS:   st_nxt.rdata_r =
                                      pick_byte(st_r.gmask_r, byte_sel);
                `PIRQ_STATUS_OFS: st_nxt.rdata_r = pick_byte(pstat, byte_sel);
                `PIRQ_MASK_OFS:   st_nxt.rdata_r =
                                      pick_byte(st_r.pmask_r, byte_sel);
                default:          st_nxt.rdata_r = 8'h00;
            endcase
        end
        if (req.wr_en)
        begin
            // Reserved mask bits are held at zero by the used-bit mask.
            case (word_addr)
                `GIRQ_MASK_OFS: st_nxt.gmask_r = put_byte(st_r.gmask_r,
                    byte_sel, req.wdata, `GIRQ_USED_MASK);
                `PIRQ_MASK_OFS: st_nxt.pmask_r = put_byte(st_r.pmask_r,
                    byte_sel, req.wdata, `PIRQ_USED_MASK);
                default: st_nxt.gmask_r = st_r.gmask_r;
            endcase
        end
        // A mask bit of one suppresses its flag.
        // The request is registered so that it is glitch free at the pin;
        // this costs one cycle of latency behind the sources.
        st_nxt.irq_r = any_unmasked(gstat, st_r.gmask_r) |
                       any_unmasked(pstat, st_r.pmask_r);
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge i_core_clk)
    begin
        if (i_srst)
        begin
            st_r.gmask_r  <= `MASK_RESET_VAL;
            st_r.pmask_r  <= `MASK_RESET_VAL;
            st_r.rdata_r  <= 8'h00;
            st_r.rvalid_r <= 1'b0;
            st_r.irq_r    <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // All outputs come straight from flip-flops. The read byte holds
    // until the next read so that a slow host can take it at leisure.
    assign o_rdata  = st_r.rdata_r;
    assign o_rvalid = st_r.rvalid_r;
    assign o_irq    = st_r.irq_r;

endmodule : global_interrupt_aggregator

// File: rtl/irq_agg_defines.svh
// Register offsets, field positions and reset values of the interrupt aggregator.
`ifndef IRQ_AGG_DEFINES_SVH
`define IRQ_AGG_DEFINES_SVH
`define GIRQ_STATUS_OFS    16'h0010
`define GIRQ_MASK_OFS      16'h0014
`define PIRQ_STATUS_OFS    16'h0018
`define PIRQ_MASK_OFS      16'h001C
`define GIRQ_LOOKUP_BIT    31
`define GIRQ_GPIO_BIT      30
`define PIRQ_PORT5_BIT     6
`define GIRQ_USED_MASK     32'hC0000000
`define PIRQ_USED_MASK     32'h0000004F
`define MASK_RESET_VAL     32'h00000000
`endif

// File: rtl/irq_agg_pkg.sv
// Types shared by the interrupt aggregator.
package irq_agg_pkg;
    typedef struct packed {
        logic        wr_en;
        logic        rd_en;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } byte_req_s;

    typedef struct packed {
        logic [31:0] gmask_r;
        logic [31:0] pmask_r;
        logic [7:0]  rdata_r;
        logic        rvalid_r;
        logic        irq_r;
    } agg_state_s;
endpackage : irq_agg_pkg

// File: bench/global_interrupt_aggregator_asserts.sv
// Port-level checker for the interrupt aggregator.
`timescale 1ns/1ps
module global_interrupt_aggregator_asserts
    import irq_agg_pkg::*;
#(
    parameter int NUM_LOOKUP_SRC = 8,
    parameter int NUM_GPIO_SRC   = 4
)(
    input wire logic                      i_core_clk,
    input wire logic                      i_srst,
    input wire logic                      i_wr_en,
    input wire logic                      i_rd_en,
    input wire logic [15:0]               i_addr,
    input wire logic [7:0]                i_wdata,
    input wire logic [NUM_LOOKUP_SRC-1:0] i_lookup_engine_src,
    input wire logic [NUM_GPIO_SRC-1:0]   i_gpio_ts_src,
    input wire logic [4:0]                i_port_pending,
    input wire logic [7:0]                o_rdata,
    input wire logic                      o_rvalid,
    input wire logic                      o_irq
);
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_srst);
    a_rvalid_answer: assert property (i_rd_en |=> o_rvalid)
        else $error("read got no answer");
    a_rvalid_only_read: assert property (!i_rd_en |=> !o_rvalid)
        else $error("answer without read");
    a_rdata_holds: assert property (!i_rd_en |=> $stable(o_rdata))
        else $error("read byte changed");
    a_irq_quiet: assert property (!(|i_lookup_engine_src ||
        |i_gpio_ts_src || |i_port_pending) |=> !o_irq) else $error("bad irq");
    a_lookup_flag: assert property (i_rd_en && i_addr == 16'h0010
        |=> o_rdata[7] == $past(|i_lookup_engine_src)) else $error("bit31");
    a_gpio_flag: assert property (i_rd_en && i_addr == 16'h0010
        |=> o_rdata[6] == $past(|i_gpio_ts_src)) else $error("bit30");
    a_status_rsvd: assert property (i_rd_en && i_addr > 16'h0010 &&
        i_addr < 16'h0014 |=> o_rdata == 8'h00) else $error("rsvd status");
    a_port_flags: assert property (i_rd_en && i_addr == 16'h001B |=>
        o_rdata == {1'b0, $past(i_port_pending[4]), 2'b00,
        $past(i_port_pending[3:0])}) else $error("port flags");
    a_port_upper: assert property (i_rd_en && i_addr >= 16'h0018 &&
        i_addr < 16'h001B |=> o_rdata == 8'h00) else $error("port rsvd");
endmodule : global_interrupt_aggregator_asserts
bind global_interrupt_aggregator global_interrupt_aggregator_asserts #(
    .NUM_LOOKUP_SRC(NUM_LOOKUP_SRC), .NUM_GPIO_SRC(NUM_GPIO_SRC)) u_chk (
    .i_core_clk, .i_srst, .i_wr_en, .i_rd_en, .i_addr, .i_wdata,
    .i_lookup_engine_src, .i_gpio_ts_src, .i_port_pending,
    .o_rdata, .o_rvalid, .o_irq);

// File: bench/tb_global_interrupt_aggregator.sv
// Self-checking bench for the interrupt aggregator.
`timescale 1ns/1ps
module tb_global_interrupt_aggregator;
    import irq_agg_pkg::*;
    typedef struct {
        logic [15:0] a;
        logic [7:0]  lk;
        logic [3:0]  gp;
        logic [4:0]  pp;
        logic [7:0]  e;
    } row_s;
    row_s rows [9] = '{'{16'h0010, 8'h01, 4'h0, 5'h00, 8'h80},
        '{16'h0010, 8'h00, 4'h8, 5'h00, 8'h40}, '{16'h0010, 8'h80, 4'h1, 5'h00, 8'hC0},
        '{16'h0013, 8'hFF, 4'hF, 5'h00, 8'h00}, '{16'h001B, 8'h00, 4'h0, 5'h1F, 8'h4F},
        '{16'h0018, 8'h00, 4'h0, 5'h10, 8'h00}, '{16'h0014, 8'h00, 4'h0, 5'h00, 8'h00},
        '{16'h001F, 8'h00, 4'h0, 5'h00, 8'h00}, '{16'h0020, 8'h00, 4'h0, 5'h00, 8'h00}};
    logic i_core_clk = 0, i_srst = 1, i_wr_en = 0, i_rd_en = 0, o_rvalid, o_irq;
    logic [15:0] i_addr = 0;
    logic [7:0] i_wdata = 0, i_lookup_engine_src = 0, o_rdata;
    logic [3:0] i_gpio_ts_src = 0;
    logic [4:0] i_port_pending = 0;
    int err_count = 0, checks_done = 0;
    global_interrupt_aggregator dut (.i_core_clk, .i_srst, .i_wr_en,
        .i_rd_en, .i_addr, .i_wdata, .i_lookup_engine_src, .i_gpio_ts_src,
        .i_port_pending, .o_rdata, .o_rvalid, .o_irq);
    always #5 i_core_clk = ~i_core_clk;
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED at %0t: byte %h not %h", $time, got, exp);
        end
    endtask : cmp8
    task automatic cmp1(input logic got, input logic exp);
        checks_done++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED at %0t: flag %b not %b", $time, got, exp);
        end
    endtask : cmp1
    task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
        @(posedge i_core_clk);
        {i_wr_en, i_rd_en, i_addr, i_wdata} <= {w, !w, a, d};
        @(posedge i_core_clk);
        {i_wr_en, i_rd_en} <= 2'b00;
        #1;
        if (!w) cmp1(o_rvalid, 1'b1);
        if (!w) cmp8(o_rdata, d);
    endtask : acc
    task automatic irqchk(input logic e);
        repeat (2) @(posedge i_core_clk);
        #1;
        cmp1(o_irq, e);
    endtask : irqchk
    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : end_of_test
    // Whole run needs about 90 cycles, so 2000 cycles means a hang.
    initial
    begin
        #20000;
        err_count++;
        end_of_test();
    end
    initial
    begin
        repeat (10) @(posedge i_core_clk);
        i_srst <= 1'b0;
        foreach (rows[k])
        begin
            @(posedge i_core_clk);
            {i_lookup_engine_src, i_gpio_ts_src, i_port_pending} <=
                {rows[k].lk, rows[k].gp, rows[k].pp};
            acc(0, rows[k].a, rows[k].e);
            irqchk(|{rows[k].lk, rows[k].gp, rows[k].pp});
        end
        @(posedge i_core_clk);
        {i_lookup_engine_src, i_gpio_ts_src, i_port_pending} <= 17'h00220;
        acc(1, 16'h0010, 8'hFF);
        acc(1, 16'h0014, 8'hFF);
        acc(1, 16'h0017, 8'hFF);
        acc(0, 16'h0014, 8'hC0);
        acc(0, 16'h0017, 8'h00);
        acc(0, 16'h0010, 8'hC0);
        irqchk(1'b0);
        i_port_pending <= 5'h1F;
        acc(1, 16'h001F, 8'hFF);
        acc(0, 16'h001F, 8'h4F);
        irqchk(1'b0);
        acc(1, 16'h001F, 8'h0F);
        irqchk(1'b1);
        @(posedge i_core_clk);
        i_srst <= 1'b1;
        repeat (2) @(posedge i_core_clk);
        i_srst <= 1'b0;
        acc(0, 16'h0014, 8'h00);
        acc(0, 16'h001F, 8'h00);
        end_of_test();
    end
endmodule : tb_global_interrupt_aggregator
